/* File: omcs_clk_feed.sv */
// Purpose: Outside clock source that feeds the clock input pin
// Assumes: Feed period unrelated to the system clock
// Notes:   Holds its level while stopped
`timescale 1ns/1ps
`default_nettype none
module omcs_clk_feed
    import omcs_pkg::*;
#(
    parameter realtime HALF = 31.0
) (
    // Control
    input  wire logic run,
    // Pin
    output logic      feed
);
    initial begin
        feed = 1'b0;
        forever begin
            #(HALF);
            if (run) begin
                feed = ~feed;
            end
        end
    end
endmodule
`default_nettype wire

/* File: omcs_divider.sv */
// Purpose: Enable-pulse divider, one pulse every DIV cycles
// Assumes: Synchronous active-high reset
// Notes:   Half level drives clock output when used as divide-by-four
`timescale 1ns/1ps
`default_nettype none
module omcs_divider
    import omcs_pkg::*;
#(
    parameter int DIV = 4
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Control
    input  wire logic run,
    // Outputs
    output logic      pulse,
    output logic      half_level
);
    if (DIV < 2) begin : g_bad_div
        $error("DIV must be at least 2");
    end

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          lvl_reg;
    logic          lvl_next;

    always_comb begin
        cnt_next = cnt_reg;
        lvl_next = lvl_reg;
        if (!run) begin
            cnt_next = '0;
            lvl_next = 1'b0;
        end else if (cnt_reg == LAST) begin
            cnt_next = '0;
            lvl_next = 1'b0;
        end else begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg + 1'b1 == HALF) begin
                lvl_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
            lvl_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            lvl_reg <= lvl_next;
        end
    end

    assign pulse      = run && (cnt_reg == LAST);
    assign half_level = lvl_reg;
endmodule
`default_nettype wire

/* File: omcs_pkg.sv */
// Purpose: Shared constants and types for the oscillator mode and clock select block
// Assumes: AXI4-Lite register access, one 40 MHz clock
// Notes:   Mode codes other than the multiplier code are free choices
package omcs_pkg;
    // Primary oscillator configuration codes
    localparam logic [3:0] CFG_FAST_CRYSTAL  = 4'h2;
    localparam logic [3:0] CFG_FAST_X4       = 4'h6;
    localparam logic [3:0] CFG_RC_OUT        = 4'h3;
    localparam logic [3:0] CFG_RC_GPIO       = 4'h7;
    localparam logic [3:0] CFG_INT_GPIO      = 4'h8;
    localparam logic [3:0] CFG_INT_DIV_OUT   = 4'h9;
    localparam logic [3:0] CFG_EXT_OUT       = 4'hc;
    localparam logic [3:0] CFG_EXT_GPIO      = 4'hd;

    // Register byte addresses
    localparam logic [3:0] ADDR_TRIM   = 4'h0;
    localparam logic [3:0] ADDR_CTRL   = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // Trim register fields
    localparam int TRIM_LOW_SRC_BIT = 7;
    localparam int TRIM_MULT_BIT    = 6;
    localparam int TRIM_VALUE_MSB   = 4;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam logic [7:0] TRIM_MASK  = 8'hdf;

    // Control register: frequency choice in bits 2:0
    localparam logic [2:0] FREQ_RESET  = 3'h6;
    localparam logic [2:0] FREQ_SLOW   = 3'h0;
    localparam logic [2:0] FREQ_4MHZ   = 3'h6;
    localparam logic [2:0] FREQ_8MHZ   = 3'h7;

    // Dividers
    localparam int OUT_DIV       = 4;
    localparam int LOW_FREQ_DIV  = 256;
    localparam int MULT_FACTOR   = 4;

    // Trim settle time
    localparam int CLK_HZ          = 40_000_000;
    localparam int SETTLE_US       = 1000;
    localparam int SETTLE_CYCLES   = (CLK_HZ / 1_000_000) * SETTLE_US;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic pwrup_timer;
        logic failsafe_mon;
        logic watchdog;
        logic two_speed;
    } omcs_feat_type;

    typedef struct packed {
        logic fast_osc_en;
        logic slow_osc_en;
        logic mult_en;
        logic x4_crystal;
        logic low_from_fast;
        logic start_delay;
    } omcs_osc_ctl_type;

    typedef enum logic [1:0] {
        SRC_FAST,
        SRC_SLOW,
        SRC_POST
    } omcs_src_type;
endpackage

/* File: omcs_settle.sv */
// Purpose: Counts the trim settle window after a trim write
// Assumes: Restart on each new trim write
// Notes:   Only informs the oscillator model; no software-visible flag
`timescale 1ns/1ps
`default_nettype none
module omcs_settle
    import omcs_pkg::*;
#(
    parameter int CYCLES = SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Control
    input  wire logic start,
    // Status
    output logic      busy
);
    if (CYCLES < 1) begin : g_bad_cycles
        $error("CYCLES must be at least 1");
    end

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (start) begin
            cnt_next = CW'(CYCLES);
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign busy = (cnt_reg != '0);
endmodule
`default_nettype wire

/* File: omcs_top.sv */
// Purpose: Primary oscillator mode decode, internal clock select and trim register
// Assumes: Configuration code and feature enables are static inputs
// Notes:   Oscillators are analog; this logic drives their enables and pin muxes
//
// Operation
// - Outside-clock modes need no start-up delay
// - Outside-clock mode drives clock out at Fosc/4
// - Outside-clock gpio mode frees pin as port bit6
// - RC mode drives clock out at Fosc/4
// - RC gpio mode frees pin as port bit6
// - Crystal x4 mode multiplies crystal by four
// - Crystal x4 mode hides software multiplier bit
// - Crystal multiplier only with code 0110
// - Internal primary lets software enable multiplier
// - Fast oscillator direct or through postscaler
// - Fast oscillator on for 125k to 8M
// - At 31k fast oscillator only if chosen
// - Slow oscillator on when selected or features
// - Frequency choice selects direct or postscaled source
// - Internal div-out mode: Fosc/4 out, in-pin bit7
// - Internal gpio mode: both pins are port bits
// - Trim write settles fast oscillator within 1 ms
// - Trim shift gives no completion flag
// - Trim leaves slow oscillator unaffected
// - Low source bit picks fast oscillator for 31k
// - Multiplier bit switches multiplier in internal modes
// - Multiplier bit held clear unless conditions met
// - Low source set: fast divided by 256
`timescale 1ns/1ps
`default_nettype none
module omcs_top
    import omcs_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Configuration
    input  wire logic [3:0]       osc_cfg,
    input  wire omcs_feat_type    feat_en,
    // AXI4-Lite write
    input  wire logic [3:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Oscillator control
    output omcs_osc_ctl_type      osc_ctl,
    output omcs_src_type          clk_src,
    output logic [4:0]            trim_value,
    output logic                  trim_settling,
    // Pins
    input  wire logic             port_a_bit6_in,
    input  wire logic             port_a_bit7_in,
    input  wire logic [1:0]       port_a_out,
    input  wire logic [1:0]       port_a_oe,
    output logic                  clock_out_pin_o,
    output logic                  clock_out_pin_oe,
    output logic                  clock_in_pin_o,
    output logic                  clock_in_pin_oe,
    output logic [1:0]            port_a_io_in,
    output logic                  clock_in_is_gpio,
    output logic                  clock_out_is_gpio
);
    // Mode decode
    logic mode_ext;
    logic mode_rc;
    logic mode_int;
    logic mode_x4;
    logic out_div4;
    logic mult_allowed;

    logic [7:0] trim_reg;
    logic [7:0] trim_next;
    logic [2:0] freq_reg;
    logic [2:0] freq_next;

    assign mode_ext = (osc_cfg == CFG_EXT_OUT) || (osc_cfg == CFG_EXT_GPIO);
    assign mode_rc  = (osc_cfg == CFG_RC_OUT) || (osc_cfg == CFG_RC_GPIO);
    assign mode_int = (osc_cfg == CFG_INT_GPIO) || (osc_cfg == CFG_INT_DIV_OUT);
    assign mode_x4  = (osc_cfg == CFG_FAST_X4);
    assign mult_allowed = mode_int && ((freq_reg == FREQ_4MHZ) || (freq_reg == FREQ_8MHZ));

    // Clock output divider
    logic div_level;
    assign out_div4 = (osc_cfg == CFG_EXT_OUT) || (osc_cfg == CFG_RC_OUT)
                   || (osc_cfg == CFG_INT_DIV_OUT);

    omcs_divider #(
        .DIV (OUT_DIV)
    ) u_out_div (
        .clk        (clk),
        .srst       (srst),
        .run        (out_div4),
        .pulse      (),
        .half_level (div_level)
    );

    // Trim settle timer
    logic trim_wr;
    omcs_settle #(
        .CYCLES (SETTLE_CNT)
    ) u_settle (
        .clk   (clk),
        .srst  (srst),
        .start (trim_wr),
        .busy  (trim_settling)
    );

    // Pin mux
    always_comb begin
        clock_out_is_gpio = (osc_cfg == CFG_EXT_GPIO) || (osc_cfg == CFG_RC_GPIO)
                         || (osc_cfg == CFG_INT_GPIO);
        clock_in_is_gpio  = mode_int;
        clock_out_pin_o   = out_div4 ? div_level : port_a_out[0];
        clock_out_pin_oe  = out_div4 || (clock_out_is_gpio && port_a_oe[0]);
        clock_in_pin_o    = port_a_out[1];
        clock_in_pin_oe   = clock_in_is_gpio && port_a_oe[1];
        port_a_io_in[0]   = clock_out_is_gpio ? port_a_bit6_in : 1'b0;
        port_a_io_in[1]   = clock_in_is_gpio ? port_a_bit7_in : 1'b0;
    end

    // Oscillator enables and source select
    always_comb begin
        osc_ctl.start_delay   = !(mode_ext);
        osc_ctl.x4_crystal    = mode_x4;
        osc_ctl.mult_en       = mult_allowed && trim_reg[TRIM_MULT_BIT];
        osc_ctl.low_from_fast = trim_reg[TRIM_LOW_SRC_BIT];
        osc_ctl.fast_osc_en   = (freq_reg != FREQ_SLOW)
                             || trim_reg[TRIM_LOW_SRC_BIT];
        osc_ctl.slow_osc_en   = ((freq_reg == FREQ_SLOW) && !trim_reg[TRIM_LOW_SRC_BIT])
                             || feat_en.pwrup_timer || feat_en.failsafe_mon
                             || feat_en.watchdog || feat_en.two_speed;
        if (freq_reg == FREQ_8MHZ) begin
            clk_src = SRC_FAST;
        end else if (freq_reg == FREQ_SLOW && !trim_reg[TRIM_LOW_SRC_BIT]) begin
            clk_src = SRC_SLOW;
        end else begin
            clk_src = SRC_POST;
        end
        trim_value = trim_reg[TRIM_VALUE_MSB:0];
    end

    // AXI4-Lite slave
    logic        aw_hold_reg;
    logic        aw_hold_next;
    logic [3:0]  aw_addr_reg;
    logic [3:0]  aw_addr_next;
    logic        w_hold_reg;
    logic        w_hold_next;
    logic [31:0] w_data_reg;
    logic [31:0] w_data_next;
    logic        w_strb0_reg;
    logic        w_strb0_next;
    logic        bvalid_reg;
    logic        bvalid_next;
    logic [1:0]  bresp_reg;
    logic [1:0]  bresp_next;
    logic        rvalid_reg;
    logic        rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0]  rresp_reg;
    logic [1:0]  rresp_next;
    logic        do_write;

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next  = w_hold_reg;
        w_data_next  = w_data_reg;
        w_strb0_next = w_strb0_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        trim_next    = trim_reg;
        freq_next    = freq_reg;
        trim_wr      = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_next  = 1'b1;
            w_data_next  = s_axi_wdata;
            w_strb0_next = s_axi_wstrb[0];
        end
        do_write = aw_hold_reg && w_hold_reg;
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = RESP_OKAY;
            unique case (aw_addr_reg)
                ADDR_TRIM: begin
                    if (w_strb0_reg) begin
                        trim_next = w_data_reg[7:0] & TRIM_MASK;
                        trim_wr   = 1'b1;
                    end
                end
                ADDR_CTRL: begin
                    if (w_strb0_reg) begin
                        freq_next = w_data_reg[2:0];
                    end
                end
                ADDR_STATUS: begin
                end
                default: begin
                    bresp_next = RESP_SLVERR;
                end
            endcase
        end
        if (!((freq_next == FREQ_4MHZ || freq_next == FREQ_8MHZ) && mode_int)) begin
            trim_next[TRIM_MULT_BIT] = 1'b0;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_TRIM:   rdata_next = {24'h000000, trim_reg};
                ADDR_CTRL:   rdata_next = {29'h00000000, freq_reg};
                ADDR_STATUS: rdata_next = {26'h0000000, osc_cfg, mode_x4, mult_allowed};
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_strb0_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= RESP_OKAY;
            trim_reg    <= TRIM_RESET;
            freq_reg    <= FREQ_RESET;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg  <= w_hold_next;
            w_data_reg  <= w_data_next;
            w_strb0_reg <= w_strb0_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            trim_reg    <= trim_next;
            freq_reg    <= freq_next;
        end
    end

    // Checks
    sequence s_trim_write;
        trim_wr;
    endsequence

    AST_NO_DELAY_EXT: assert property (@(posedge clk) disable iff (srst)
        mode_ext |-> !osc_ctl.start_delay)
        else $error("start delay in outside clock mode");
    AST_DIV4_PERIOD: assert property (@(posedge clk) disable iff (srst)
        (out_div4 && $rose(div_level)) |-> ##4 $rose(div_level) || !out_div4)
        else $error("clock output not Fosc/4");
    AST_GPIO6: assert property (@(posedge clk) disable iff (srst)
        clock_out_is_gpio |-> (port_a_io_in[0] == port_a_bit6_in))
        else $error("bit6 not passed in gpio mode");
    AST_X4_CODE: assert property (@(posedge clk) disable iff (srst)
        osc_ctl.x4_crystal |-> (osc_cfg == 4'h6))
        else $error("crystal multiplier with wrong code");
    AST_MULT_CLEAR: assert property (@(posedge clk) disable iff (srst)
        !mult_allowed |=> !trim_reg[TRIM_MULT_BIT])
        else $error("multiplier bit set while unavailable");
    AST_FAST_EN: assert property (@(posedge clk) disable iff (srst)
        (freq_reg != FREQ_SLOW) |-> osc_ctl.fast_osc_en)
        else $error("fast oscillator off at high frequency");
    AST_SLOW_FEAT: assert property (@(posedge clk) disable iff (srst)
        feat_en.watchdog |-> osc_ctl.slow_osc_en)
        else $error("slow oscillator off with watchdog");
    AST_SETTLE: assert property (@(posedge clk) disable iff (srst)
        s_trim_write |=> trim_settling && (trim_value == $past(trim_next[4:0])))
        else $error("trim settle not started");
endmodule
`default_nettype wire

/* File: oscillator_mode_clock_select_tb_top.sv */
// Purpose: Register and pin checks of the oscillator mode block
// Assumes: AXI4-Lite master tasks, one 40 MHz clock
// Notes:   Settle count shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module oscillator_mode_clock_select_tb_top;
    import omcs_pkg::*;
    localparam int SETTLE_N = 20;
    localparam logic [3:0] CODES [8] = '{CFG_FAST_CRYSTAL, CFG_FAST_X4, CFG_RC_OUT,
        CFG_RC_GPIO, CFG_INT_GPIO, CFG_INT_DIV_OUT, CFG_EXT_OUT, CFG_EXT_GPIO};
    localparam logic [7:0] OUTG = 8'h98;
    localparam logic [7:0] ING  = 8'h30;
    localparam logic [7:0] SD   = 8'h3f;
    localparam logic [7:0] DIV4 = 8'h64;
    localparam logic [7:0] X4   = 8'h02;
    logic             clk, srst, feed_run, feed_lvl, pin6_drv;
    logic [3:0]       osc_cfg, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    omcs_feat_type    feat_en;
    logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic             s_axi_rvalid, s_axi_rready, trim_settling;
    logic [31:0]      s_axi_wdata, s_axi_rdata, d;
    logic [1:0]       s_axi_bresp, s_axi_rresp, r, port_a_out, port_a_oe, port_a_io_in;
    omcs_osc_ctl_type osc_ctl;
    omcs_src_type     clk_src;
    logic [4:0]       trim_value;
    logic             clock_out_pin_o, clock_out_pin_oe, clock_in_pin_o, clock_in_pin_oe;
    logic             clock_in_is_gpio, clock_out_is_gpio, p;
    wire logic        port_a_bit6_in;
    wire logic        port_a_bit7_in;
    int               miscompares, n_checks, t;

    assign port_a_bit6_in = clock_out_pin_oe ? clock_out_pin_o : pin6_drv;
    assign port_a_bit7_in = clock_in_pin_oe ? clock_in_pin_o : feed_lvl;

    omcs_top #(.SETTLE_CNT(SETTLE_N)) dut (.clk, .srst, .osc_cfg, .feat_en,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .osc_ctl, .clk_src, .trim_value, .trim_settling,
        .port_a_bit6_in, .port_a_bit7_in, .port_a_out, .port_a_oe, .clock_out_pin_o,
        .clock_out_pin_oe, .clock_in_pin_o, .clock_in_pin_oe, .port_a_io_in,
        .clock_in_is_gpio, .clock_out_is_gpio);
    omcs_clk_feed u_feed (.run(feed_run), .feed(feed_lvl));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic guard(input int n);
        if (n > 64) begin
            miscompares++;
            $display("[FAIL] bus wait expected answer seen none");
            tally_and_finish();
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
        int  n;
        logic aw_ok;
        logic w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            n++;
            guard(n);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            guard(n);
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            guard(n);
        end while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            guard(n);
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic do_reset(input logic [3:0] cfg);
        osc_cfg <= cfg;
        srst    <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        {pin6_drv, s_axi_awvalid, s_axi_wvalid} <= 3'h0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} <= 3'h0;
        {s_axi_awaddr, s_axi_wstrb, s_axi_araddr} <= 12'h0;
        s_axi_wdata <= 32'h0;
        feat_en     <= omcs_feat_type'(4'h0);
        port_a_out  <= 2'h0;
        port_a_oe   <= 2'h0;
        for (int i = 0; i < 8; i++) begin
            feed_run <= ~ING[i];
            do_reset(CODES[i]);
            axi_rd(ADDR_TRIM);
            chk("trim reset", {24'h0, TRIM_RESET}, d);
            axi_rd(ADDR_CTRL);
            chk("ctrl reset", {29'h0, FREQ_RESET}, d);
            axi_rd(ADDR_STATUS);
            chk("status", {26'h0, CODES[i], X4[i], ING[i]}, d);
            chk("out gpio", OUTG[i], clock_out_is_gpio);
            chk("in gpio", ING[i], clock_in_is_gpio);
            chk("start delay", SD[i], osc_ctl.start_delay);
            chk("x4 crystal", X4[i], osc_ctl.x4_crystal);
            step();
            t = 0;
            repeat (16) begin
                p = clock_out_pin_o;
                step();
                t += (clock_out_pin_o !== p);
            end
            if (DIV4[i]) begin
                chk("div4 edges", 8, t);
                chk("div4 oe", 1, clock_out_pin_oe);
            end else begin
                chk("no clock out", 0, t);
            end
            axi_wr(ADDR_TRIM, 32'h40, 4'h1);
            axi_rd(ADDR_TRIM);
            chk("mult bit", ING[i] ? 32'h40 : 32'h0, d);
            chk("mult en", ING[i], osc_ctl.mult_en);
            pin6_drv   <= 1'b1;
            port_a_oe  <= 2'b11;
            port_a_out <= 2'b10;
            step();
            chk("in pin oe", ING[i], clock_in_pin_oe);
            chk("in pin port", ING[i], port_a_io_in[1]);
            if (OUTG[i]) begin
                chk("out pin oe", 1, clock_out_pin_oe);
                chk("out pin port", 0, port_a_io_in[0]);
            end
            port_a_oe <= 2'b00;
            step();
            if (OUTG[i]) begin
                chk("out pin read", 1, port_a_io_in[0]);
            end
        end
        $display("test modes done");
        feed_run <= 1'b0;
        do_reset(CFG_INT_DIV_OUT);
        for (int j = 0; j < 3; j++) begin
            axi_wr(ADDR_CTRL, (j == 0) ? 32'h0 : ((j == 1) ? 32'h3 : 32'h7), 4'h1);
            step();
            chk("src", (j == 0) ? SRC_SLOW : ((j == 1) ? SRC_POST : SRC_FAST), clk_src);
            chk("fast en", j != 0, osc_ctl.fast_osc_en);
            chk("slow en", j == 0, osc_ctl.slow_osc_en);
        end
        for (int k = 0; k < 4; k++) begin
            feat_en <= omcs_feat_type'(4'h1 << k);
            step();
            chk("slow by feature", 1, osc_ctl.slow_osc_en);
        end
        feat_en <= omcs_feat_type'(4'h0);
        axi_wr(ADDR_CTRL, 32'h0, 4'h1);
        axi_wr(ADDR_TRIM, 32'h80, 4'h1);
        step();
        chk("low from fast", 1, osc_ctl.low_from_fast);
        chk("fast at 31k", 1, osc_ctl.fast_osc_en);
        chk("slow off at 31k", 0, osc_ctl.slow_osc_en);
        $display("test sources done");
        axi_wr(ADDR_CTRL, {29'h0, FREQ_8MHZ}, 4'h1);
        axi_wr(ADDR_TRIM, 32'h40, 4'h1);
        axi_rd(ADDR_TRIM);
        chk("mult set", 32'h40, d);
        axi_wr(ADDR_CTRL, 32'h5, 4'h1);
        axi_rd(ADDR_TRIM);
        chk("mult dropped", 32'h0, d);
        chk("mult off", 0, osc_ctl.mult_en);
        axi_wr(ADDR_TRIM, 32'h3f, 4'h1);
        chk_resp("trim resp", RESP_OKAY, r);
        #1;
        chk("trim value", 5'h1f, trim_value);
        chk("settling", 1, trim_settling);
        chk("src kept", SRC_POST, clk_src);
        axi_rd(ADDR_STATUS);
        chk("no done flag", {26'h0, CFG_INT_DIV_OUT, 2'b00}, d);
        repeat (SETTLE_N) step();
        chk("settled", 0, trim_settling);
        axi_rd(ADDR_TRIM);
        chk("bit5 zero", 32'h1f, d);
        axi_wr(ADDR_TRIM, 32'h05, 4'h0);
        axi_rd(ADDR_TRIM);
        chk("strb off", 32'h1f, d);
        axi_rd(4'hc);
        chk_resp("unmapped rd", RESP_SLVERR, r);
        chk("unmapped data", 32'h0, d);
        axi_wr(4'hc, 32'h1, 4'h1);
        chk_resp("unmapped wr", RESP_SLVERR, r);
        $display("test trim done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
